//--- hdl/dio_port.sv
/*
 * On-board digital I/O port: sixteen filtered inputs with edge interrupts
 * and lost-interrupt diagnostics, twelve outputs, lamps, register port.
 * Assumes field pins are asynchronous and a bus master that changes its
 * signals right after the rising edge and never strobes read and write together.
 */
`timescale 1ns/1ns
module dio_port
	import dio_pkg::*;
#(
	parameter int P_DLY_0P5_CYC = DLY_0P5_CYC,
	parameter int P_DLY_3_CYC   = DLY_3_CYC,
	parameter int P_DLY_15_CYC  = DLY_15_CYC
) (
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [7:0]        i_addr,
	input  wire logic [7:0]        i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [7:0]        o_rdata,
	output logic                   o_irq,
	input  wire logic [N_IN-1:0]   i_field_input_line,
	input  wire field_pins_s       i_pins,
	output logic      [N_OUT-1:0]  o_field_output_line,
	output logic      [N_IN-1:0]   o_in_lamp,
	output logic      [N_OUT-1:0]  o_out_lamp,
	output lamps_s                 o_lamps
);

	// Address hits one of a low/high byte pair
	function automatic logic pair_hit(input logic [7:0] a, input logic [7:0] base);
		pair_hit = (a[7:1] == base[7:1]);
	endfunction : pair_hit

	// Replace one byte of a 16-bit register
	function automatic logic [15:0] put_byte(input logic [15:0] old,
		input logic [7:0] d, input logic hi);
		put_byte = hi ? {d, old[7:0]} : {old[15:8], d};
	endfunction : put_byte

	// Byte mask of ones written to a W1C pair
	function automatic logic [15:0] w1c_mask(input logic [7:0] d, input logic hi);
		w1c_mask = hi ? {d, 8'h00} : {8'h00, d};
	endfunction : w1c_mask

	// Delay code to cycle limit; slow lines never go below 0.5 ms
	function automatic logic [CNT_W-1:0] dly_limit(input logic [1:0] code,
		input logic fast);
		unique case (code)
			DSEL_0P1: dly_limit = fast ? CNT_W'(DLY_0P1_CYC) : CNT_W'(P_DLY_0P5_CYC);
			DSEL_0P5: dly_limit = CNT_W'(P_DLY_0P5_CYC);
			DSEL_3:   dly_limit = CNT_W'(P_DLY_3_CYC);
			DSEL_15:  dly_limit = CNT_W'(P_DLY_15_CYC);
		endcase
	endfunction : dly_limit

	logic [N_IN-1:0]  in_meta_r;
	logic [N_IN-1:0]  in_sync_r;
	field_pins_s      pins_meta_r;
	field_pins_s      pins_sync_r;
	logic [N_IN-1:0]  level_w;
	logic [N_IN-1:0]  level_d_r;
	logic [N_IN-1:0]  rise_w;
	logic [N_IN-1:0]  fall_w;
	logic [N_IN-1:0]  edge_evt_w;
	logic [N_IN-1:0]  lost_evt_w;
	logic [CNT_W-1:0] lim_w [N_IN];
	logic [15:0]      rise_en_r;
	logic [15:0]      fall_en_r;
	logic [15:0]      edge_stat_r;
	logic [15:0]      edge_mask_r;
	logic [15:0]      lost_stat_r;
	logic [15:0]      lost_mask_r;
	logic [7:0]       delay_sel_r;
	logic [11:0]      out_r;
	logic [15:0]      edge_clr_w;
	logic [15:0]      lost_clr_w;
	logic             wr_hi;

	assign wr_hi = i_addr[0];

	// Two-flop synchronisers; only the second stage feeds logic
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			in_meta_r   <= '0;
			in_sync_r   <= '0;
			pins_meta_r <= '0;
			pins_sync_r <= '0;
		end else begin
			in_meta_r   <= i_field_input_line;
			in_sync_r   <= in_meta_r;
			pins_meta_r <= i_pins;
			pins_sync_r <= pins_meta_r;
		end
	end

	// One filter per line; the group setting is picked by line index
	genvar g;
	generate
		for (g = 0; g < N_IN; g++) begin : gen_in
			assign lim_w[g] = dly_limit(delay_sel_r[2*(g/GRP_SZ) +: 2], FAST_MASK[g]);

			dio_input_filter u_filt (
				.i_clk   (i_clk),
				.i_rst   (i_rst),
				.i_raw   (in_sync_r[g]),
				.i_limit (lim_w[g]),
				.o_level (level_w[g])
			);

			if (!FAST_MASK[g]) begin : gen_slow
				AST_SLOW_MIN: assert property (@(posedge i_clk) disable iff (i_rst)
					lim_w[g] >= CNT_W'(P_DLY_0P5_CYC))
					else $error("slow line filtered below the half-millisecond floor");
			end
		end
	endgenerate

	// Previous filtered level for edge detection
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			level_d_r <= '0;
		end else begin
			level_d_r <= level_w;
		end
	end

	// Edges are taken from the filtered level, never the raw pin
	assign rise_w     = level_w & ~level_d_r;
	assign fall_w     = ~level_w & level_d_r;
	assign edge_evt_w = (rise_w & rise_en_r) | (fall_w & fall_en_r);
	assign lost_evt_w = edge_evt_w & edge_stat_r;

	// Status clear strobes from the register port
	assign edge_clr_w = (i_wr && pair_hit(i_addr, A_EDGE_STAT)) ?
		w1c_mask(i_wdata, wr_hi) : 16'h0000;
	assign lost_clr_w = (i_wr && pair_hit(i_addr, A_LOST_STAT)) ?
		w1c_mask(i_wdata, wr_hi) : 16'h0000;

	// Edge enables, masks and delay selection written by software
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rise_en_r   <= RST_EN;
			fall_en_r   <= RST_EN;
			edge_mask_r <= RST_EN;
			lost_mask_r <= RST_EN;
			delay_sel_r <= RST_DELAY;
		end else if (i_wr) begin
			if (pair_hit(i_addr, A_RISE_EN))
				rise_en_r <= put_byte(rise_en_r, i_wdata, wr_hi);
			if (pair_hit(i_addr, A_FALL_EN))
				fall_en_r <= put_byte(fall_en_r, i_wdata, wr_hi);
			if (pair_hit(i_addr, A_EDGE_MASK))
				edge_mask_r <= put_byte(edge_mask_r, i_wdata, wr_hi);
			if (pair_hit(i_addr, A_LOST_MASK))
				lost_mask_r <= put_byte(lost_mask_r, i_wdata, wr_hi);
			if (i_addr == A_DELAY_SEL)
				delay_sel_r <= i_wdata;
		end
	end

	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			edge_stat_r <= '0;
			lost_stat_r <= '0;
		end else begin
			edge_stat_r <= (edge_stat_r & ~edge_clr_w) | edge_evt_w;
			lost_stat_r <= (lost_stat_r & ~lost_clr_w) | lost_evt_w;
		end
	end

	// Process-image outputs; only bits 0-3 of the high byte exist
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			out_r <= RST_OUT;
		end else if (i_wr && i_addr == A_IO_LO) begin
			out_r[7:0] <= i_wdata;
		end else if (i_wr && i_addr == A_IO_HI) begin
			out_r[11:8] <= i_wdata[3:0];
		end
	end

	// Read mux; the shared I/O locations read back the inputs
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			o_rdata <= 8'h00;
			if (i_addr == A_IO_LO)
				o_rdata <= level_w[7:0];
			else if (i_addr == A_IO_HI)
				o_rdata <= level_w[15:8];
			else if (pair_hit(i_addr, A_RISE_EN))
				o_rdata <= wr_hi ? rise_en_r[15:8] : rise_en_r[7:0];
			else if (pair_hit(i_addr, A_FALL_EN))
				o_rdata <= wr_hi ? fall_en_r[15:8] : fall_en_r[7:0];
			else if (pair_hit(i_addr, A_EDGE_STAT))
				o_rdata <= wr_hi ? edge_stat_r[15:8] : edge_stat_r[7:0];
			else if (pair_hit(i_addr, A_EDGE_MASK))
				o_rdata <= wr_hi ? edge_mask_r[15:8] : edge_mask_r[7:0];
			else if (pair_hit(i_addr, A_LOST_STAT))
				o_rdata <= wr_hi ? lost_stat_r[15:8] : lost_stat_r[7:0];
			else if (pair_hit(i_addr, A_LOST_MASK))
				o_rdata <= wr_hi ? lost_mask_r[15:8] : lost_mask_r[7:0];
			else if (i_addr == A_DELAY_SEL)
				o_rdata <= delay_sel_r;
			else if (i_addr == A_PORT_STAT) begin
				o_rdata[PS_OVERLOAD]  <= pins_sync_r.overload;
				o_rdata[PS_SENS_FAIL] <= pins_sync_r.sensor_fault;
			end
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Interrupt line, registered so it changes only on the clock
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |((edge_stat_r & edge_mask_r) | (lost_stat_r & lost_mask_r));
		end
	end

	// Field outputs and lamps, all straight from flops
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_field_output_line <= RST_OUT;
			o_out_lamp          <= RST_OUT;
			o_in_lamp           <= '0;
			o_lamps             <= '0;
		end else begin
			o_field_output_line <= out_r;
			o_out_lamp          <= out_r;
			o_in_lamp           <= level_w;
			o_lamps.output_overload_lamp     <= pins_sync_r.overload;
			o_lamps.sensor_supply_fault_lamp <= pins_sync_r.sensor_fault;
			o_lamps.electronics_supply_lamp  <= pins_sync_r.elec_ok;
			o_lamps.output_supply_lamp       <= pins_sync_r.out_supply_ok;
			o_lamps.module_bus_supply_lamp   <= pins_sync_r.bus_ok;
			o_lamps.input_supply_lamp        <= pins_sync_r.in_supply_ok;
		end
	end

	// Cycle of an edge arriving while the previous one is unacknowledged
	sequence s_pending_edge;
		(edge_evt_w & edge_stat_r & ~edge_clr_w) != 16'h0000;
	endsequence

	AST_EDGE_SETS: assert property (@(posedge i_clk) disable iff (i_rst)
		edge_evt_w != 16'h0000 |=> (edge_stat_r & $past(edge_evt_w)) == $past(edge_evt_w))
		else $error("enabled edge did not set its status bit");

	AST_NO_UNSEL: assert property (@(posedge i_clk) disable iff (i_rst)
		(edge_stat_r & ~$past(edge_stat_r) & ~$past(edge_evt_w)) == 16'h0000)
		else $error("status set without a selected edge");

	AST_RST_OFF: assert property (@(posedge i_clk)
		$past(i_rst) |-> rise_en_r == 16'h0000 && fall_en_r == 16'h0000)
		else $error("edge enables not off after reset");

	AST_EDGE_DIR: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 (rise_w == (level_w & ~$past(level_w))) && (fall_w == (~level_w & $past(level_w))))
		else $error("edge direction wrong");

	AST_LOST_ONLY: assert property (@(posedge i_clk) disable iff (i_rst)
		(lost_stat_r & ~$past(lost_stat_r) & ~$past(edge_evt_w & edge_stat_r)) == 16'h0000)
		else $error("diagnostic raised without a lost edge");

	AST_LOST_SET: assert property (@(posedge i_clk) disable iff (i_rst)
		s_pending_edge |=> lost_stat_r != 16'h0000 ##1 1'b1)
		else $error("edge on a pending line not flagged lost");

	AST_READ_IN: assert property (@(posedge i_clk) disable iff (i_rst)
		i_rd && i_addr == A_IO_HI |=> o_rdata == $past(level_w[15:8]))
		else $error("input byte 137 read wrong");

	AST_WRITE_OUT: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == A_IO_LO |=> ##1 o_field_output_line[7:0] == $past(i_wdata, 2))
		else $error("output byte 136 not driven");

	AST_IN_LAMP: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 o_in_lamp == $past(level_w))
		else $error("input lamp does not follow the line");

	AST_OUT_LAMP: assert property (@(posedge i_clk) disable iff (i_rst)
		o_out_lamp == o_field_output_line)
		else $error("output lamp does not follow the output");

	AST_FAULT_LAMP: assert property (@(posedge i_clk) disable iff (i_rst)
		pins_sync_r.overload |=> o_lamps.output_overload_lamp)
		else $error("overload lamp dark during overload");

	AST_SENS_LAMP: assert property (@(posedge i_clk) disable iff (i_rst)
		##1 o_lamps.sensor_supply_fault_lamp == $past(pins_sync_r.sensor_fault))
		else $error("sensor supply lamp wrong");

endmodule : dio_port

//--- include/dio_pkg.sv
/*
 * Shared constants and carriers for the on-board digital I/O port:
 * register offsets, field layout, filter delay codes and timing counts.
 * Assumes a 10 MHz core clock and an 8-bit register port.
 */
package dio_pkg;

	// Core clock
	localparam int CLK_PERIOD_NS = 100;

	// Port geometry
	localparam int N_IN   = 16;
	localparam int N_OUT  = 12;
	localparam int N_GRP  = 4;
	localparam int GRP_SZ = 4;
	localparam int CNT_W  = 18;

	// Lines able to run at the high input rate
	localparam logic [15:0] FAST_MASK = 16'h8ED8;

	// Input delay times in ns, as offered
	localparam int DLY_0P1_NS = 100000;
	localparam int DLY_0P5_NS = 500000;
	localparam int DLY_3_NS   = 3000000;
	localparam int DLY_15_NS  = 15000000;

	// Cycle counts derived from the clock period
	localparam int DLY_0P1_CYC = DLY_0P1_NS / CLK_PERIOD_NS;
	localparam int DLY_0P5_CYC = DLY_0P5_NS / CLK_PERIOD_NS;
	localparam int DLY_3_CYC   = DLY_3_NS / CLK_PERIOD_NS;
	localparam int DLY_15_CYC  = DLY_15_NS / CLK_PERIOD_NS;

	// Delay selection codes, two bits per group
	localparam logic [1:0] DSEL_0P1 = 2'h0;
	localparam logic [1:0] DSEL_0P5 = 2'h1;
	localparam logic [1:0] DSEL_3   = 2'h2;
	localparam logic [1:0] DSEL_15  = 2'h3;

	// Register offsets (byte addresses); pairs share bit 0 as low/high byte
	localparam logic [7:0] A_IO_LO      = 8'h88;
	localparam logic [7:0] A_IO_HI      = 8'h89;
	localparam logic [7:0] A_RISE_EN    = 8'h90;
	localparam logic [7:0] A_FALL_EN    = 8'h92;
	localparam logic [7:0] A_EDGE_STAT  = 8'h94;
	localparam logic [7:0] A_EDGE_MASK  = 8'h96;
	localparam logic [7:0] A_LOST_STAT  = 8'h98;
	localparam logic [7:0] A_LOST_MASK  = 8'h9A;
	localparam logic [7:0] A_DELAY_SEL  = 8'h9C;
	localparam logic [7:0] A_PORT_STAT  = 8'h9D;

	// Reset values
	localparam logic [15:0] RST_EN    = 16'h0000;
	localparam logic [7:0]  RST_DELAY = 8'h00;
	localparam logic [11:0] RST_OUT   = 12'h000;

	// Port status bit positions
	localparam int PS_OVERLOAD  = 0;
	localparam int PS_SENS_FAIL = 1;

	// Supply and fault pins from the field side
	typedef struct packed {
		logic overload;
		logic sensor_fault;
		logic elec_ok;
		logic out_supply_ok;
		logic bus_ok;
		logic in_supply_ok;
	} field_pins_s;

	// Module-level lamps
	typedef struct packed {
		logic sensor_supply_fault_lamp;
		logic output_overload_lamp;
		logic electronics_supply_lamp;
		logic output_supply_lamp;
		logic module_bus_supply_lamp;
		logic input_supply_lamp;
	} lamps_s;

endpackage : dio_pkg

//--- hdl/dio_input_filter.sv
/*
 * One input line's delay filter: the reported level follows the raw
 * level only after it has differed for the chosen number of cycles.
 * Assumes i_raw is already synchronised to i_clk.
 */
`timescale 1ns/1ns
module dio_input_filter
	import dio_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_raw,
	input  wire logic [CNT_W-1:0] i_limit,
	output logic                  o_level
);

	logic [CNT_W-1:0] cnt_r;
	logic             level_r;

	assign o_level = level_r;

	// Stability counter; any bounce back to the old level restarts it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r   <= '0;
			level_r <= 1'b0;
		end else if (i_raw == level_r) begin
			cnt_r <= '0;
		end else if (cnt_r >= i_limit - 1'b1) begin
			level_r <= i_raw;
			cnt_r   <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	sequence s_differs_full;
		(i_raw != level_r) && (cnt_r >= i_limit - 1'b1);
	endsequence

	AST_FILT_STABLE: assert property (@(posedge i_clk) disable iff (i_rst)
		$changed(level_r) |-> $past(cnt_r >= i_limit - 1'b1) && $past(i_raw) == level_r)
		else $error("filtered level changed before the delay ran out");

	AST_FILT_TAKES: assert property (@(posedge i_clk) disable iff (i_rst)
		s_differs_full |=> level_r == $past(i_raw))
		else $error("filtered level missed a stable change");

endmodule : dio_input_filter

//--- dv/dio_field_model.sv
/*
 * Field-side model: sensor levels on the input lines, supply-ok pins,
 * a sensor supply fault and a short on the output wiring.
 * Assumes its tasks are called from the bench's clocked sequence.
 */
`timescale 1ns/1ns
module dio_field_model
	import dio_pkg::*;
(
	input  wire logic             i_clk,
	input  wire logic [N_OUT-1:0] i_out,
	output logic      [N_IN-1:0]  o_line,
	output field_pins_s           o_pins
);
	logic       short_r;
	logic       sens_err_r;
	logic [3:0] supply_r;

	// A short only shows as overload while some output is driven high
	assign o_pins = {short_r & (|i_out), sens_err_r, supply_r};

	// All supplies present until a scenario drops one
	initial begin
		o_line = '0;
		short_r = 1'b0;
		sens_err_r = 1'b0;
		supply_r = 4'hf;
	end

	// Sensor levels change just after a rising edge
	task automatic set_lines(input logic [N_IN-1:0] v);
		@(posedge i_clk);
		o_line <= v;
	endtask : set_lines

	task automatic set_faults(input logic s, input logic e);
		@(posedge i_clk);
		short_r <= s;
		sens_err_r <= e;
	endtask : set_faults

	// Supply-ok pins: electronics, outputs, module bus, inputs
	task automatic set_supply(input logic [3:0] v);
		@(posedge i_clk);
		supply_r <= v;
	endtask : set_supply
endmodule : dio_field_model

//--- dv/dio_port_test.sv
/*
 * Self-checking bench for the digital I/O port: register port tasks,
 * filter delays, edge and lost interrupts, outputs and lamps.
 * Assumes shortened 0.5/3/15 ms counts; 0.1 ms stays 1000 cycles.
 */
`timescale 1ns/1ns
module dio_port_test
	import dio_pkg::*;
;
	localparam int L05 = 2000;
	localparam int L3  = 3000;
	localparam int L15 = 4000;

	logic              i_clk = 1'b0;
	logic              i_rst = 1'b1;
	logic [7:0]        i_addr = 8'h00;
	logic [7:0]        i_wdata = 8'h00;
	logic              i_wr = 1'b0;
	logic              i_rd = 1'b0;
	logic [7:0]        o_rdata;
	logic              o_irq;
	logic [N_IN-1:0]   line;
	field_pins_s       pins;
	logic [N_OUT-1:0]  o_field_output_line;
	logic [N_IN-1:0]   o_in_lamp;
	logic [N_OUT-1:0]  o_out_lamp;
	lamps_s            o_lamps;
	int                num_errors = 0;
	int                n_checks = 0;

	always #50 i_clk = ~i_clk;

	dio_port #(.P_DLY_0P5_CYC(L05), .P_DLY_3_CYC(L3), .P_DLY_15_CYC(L15)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
		.i_field_input_line(line), .i_pins(pins),
		.o_field_output_line(o_field_output_line), .o_in_lamp(o_in_lamp),
		.o_out_lamp(o_out_lamp), .o_lamps(o_lamps));

	dio_field_model field (.i_clk(i_clk), .i_out(o_field_output_line), .o_line(line),
		.o_pins(pins));

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic final_report();
		$display("Checks %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Data stand only in the cycle after the strobe, so sample mid-cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		check({8'h00, o_rdata}, {8'h00, exp});
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc

	// Raise and drop one line; lamp must hold off until the delay has run
	task automatic check_delay(input int ln, input logic [1:0] code);
		int l;
		logic [15:0] bit_m;
		bit_m = 16'h0001 << ln;
		case (code)
			DSEL_0P1: l = FAST_MASK[ln] ? DLY_0P1_CYC : L05;
			DSEL_0P5: l = L05;
			DSEL_3:   l = L3;
			default:  l = L15;
		endcase
		wr(A_DELAY_SEL, 8'(code) << (2 * (ln / 4)));
		field.set_lines(bit_m);
		cyc(l - 8);
		check(o_in_lamp & bit_m, 16'h0000);
		cyc(20);
		check(o_in_lamp & bit_m, bit_m);
		field.set_lines(16'h0000);
		cyc(l + 12);
		check(o_in_lamp & bit_m, 16'h0000);
	endtask : check_delay

	initial begin
		cyc(80000);
		num_errors++;
		final_report();
	end

	initial begin
		cyc(12);
		i_rst <= 1'b0;
		// Every own register is clear after reset, unmapped reads give zero
		for (int a = 16'h0090; a <= 16'h009d; a++) begin
			rd(8'(a), 8'h00);
		end
		rd(8'hf0, 8'h00);
		// High bytes of the pair registers keep their own bits
		wr(A_RISE_EN | 8'h01, 8'h81);
		wr(A_FALL_EN | 8'h01, 8'h42);
		wr(A_EDGE_MASK | 8'h01, 8'h24);
		wr(A_LOST_MASK | 8'h01, 8'h18);
		rd(A_RISE_EN | 8'h01, 8'h81);
		rd(A_FALL_EN | 8'h01, 8'h42);
		rd(A_EDGE_MASK | 8'h01, 8'h24);
		rd(A_LOST_MASK | 8'h01, 8'h18);
		rd(A_RISE_EN, 8'h00);
		rd(A_FALL_EN, 8'h00);
		wr(A_RISE_EN | 8'h01, 8'h00);
		wr(A_FALL_EN | 8'h01, 8'h00);
		wr(A_EDGE_MASK | 8'h01, 8'h00);
		wr(A_LOST_MASK | 8'h01, 8'h00);
		// Input byte mapping, default delay code on all groups
		field.set_lines(16'h5a3c);
		cyc(L05 + 20);
		rd(A_IO_LO, 8'h3c);
		rd(A_IO_HI, 8'h5a);
		check(o_in_lamp, 16'h5a3c);
		field.set_lines(16'h0000);
		cyc(L05 + 20);
		check(o_in_lamp, 16'h0000);
		// Filter delays, line 4 on every code, then lines 5, 3 and 13 on the 0.1 ms code
		for (int c = 0; c < 4; c++) begin
			check_delay(4, 2'(c));
		end
		check_delay(5, DSEL_0P1);
		check_delay(3, DSEL_0P1);
		check_delay(13, DSEL_0P1);
		wr(A_DELAY_SEL, 8'h00);
		// Rising edge only: falling edge must not set the status bit
		wr(A_RISE_EN, 8'h10);
		wr(A_EDGE_MASK, 8'h10);
		field.set_lines(16'h0010);
		cyc(1020);
		rd(A_EDGE_STAT, 8'h10);
		check({15'h0, o_irq}, 16'h0001);
		wr(A_EDGE_STAT, 8'h10);
		cyc(3);
		check({15'h0, o_irq}, 16'h0000);
		field.set_lines(16'h0000);
		cyc(1020);
		rd(A_EDGE_STAT, 8'h00);
		rd(A_LOST_STAT, 8'h00);
		// Falling edge while the rising one is still pending is lost
		wr(A_FALL_EN, 8'h10);
		field.set_lines(16'h0010);
		cyc(1020);
		field.set_lines(16'h0000);
		cyc(1020);
		rd(A_LOST_STAT, 8'h10);
		wr(A_EDGE_MASK, 8'h00);
		wr(A_EDGE_STAT, 8'h10);
		cyc(3);
		check({15'h0, o_irq}, 16'h0000);
		wr(A_LOST_MASK, 8'h10);
		cyc(3);
		check({15'h0, o_irq}, 16'h0001);
		wr(A_LOST_STAT, 8'h10);
		cyc(3);
		check({15'h0, o_irq}, 16'h0000);
		rd(A_LOST_STAT, 8'h00);
		// Outputs from both bytes, upper nibble of the high byte unused
		wr(A_IO_LO, 8'ha5);
		wr(A_IO_HI, 8'hfc);
		cyc(3);
		check({4'h0, o_field_output_line}, 16'h0ca5);
		check({4'h0, o_out_lamp}, 16'h0ca5);
		// Short on driven outputs and a sensor supply error
		field.set_faults(1'b1, 1'b1);
		cyc(6);
		check({10'h000, o_lamps}, {10'h000, 6'h3f});
		rd(A_PORT_STAT, 8'h03);
		wr(A_IO_LO, 8'h00);
		wr(A_IO_HI, 8'h00);
		field.set_faults(1'b0, 1'b0);
		cyc(6);
		check({10'h000, o_lamps}, {10'h000, 6'h0f});
		check({4'h0, o_out_lamp}, 16'h0000);
		// Each supply lamp follows its own supply pin
		field.set_supply(4'h5);
		cyc(6);
		check({10'h000, o_lamps}, {10'h000, 6'h05});
		field.set_supply(4'ha);
		cyc(6);
		check({10'h000, o_lamps}, {10'h000, 6'h0a});
		field.set_supply(4'hf);
		rd(A_PORT_STAT, 8'h00);
		final_report();
	end
endmodule : dio_port_test
